// >>> inc/icbu_pkg.sv
// Purpose : Shared constants and carriers for the fetch/bus-unit error bank
// Assumes : MSR numbers are 32-bit, register data 64-bit
// Notes   : Status layout follows the data-cache status register
`default_nettype none
package icbu_pkg;
    // ----------------------------------------
    // Register numbers
    // ----------------------------------------
    localparam logic [31:0] ADR_IC_CTL  = 32'h0000_0404;
    localparam logic [31:0] ADR_IC_STAT = 32'h0000_0405;
    localparam logic [31:0] ADR_IC_ADDR = 32'h0000_0406;
    localparam logic [31:0] ADR_BU_CTL  = 32'h0000_0408;
    localparam logic [31:0] ADR_IC_MASK = 32'hc001_0045;
    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int ST_VALID      = 63;
    localparam int ST_OVER       = 62;
    localparam int ST_UNCOR      = 61;
    localparam int ST_EN         = 60;
    localparam int ST_ADDR_VALID = 58;
    localparam int ST_CTX_BAD    = 57;
    localparam int ST_CORR_ECC   = 46;
    localparam int ST_UNCOR_ECC  = 45;
    localparam int ST_SCRUB      = 40;
    localparam int ST_EXT        = 16;
    localparam logic [3:0] EXT_PLAIN = 4'h0;
    localparam logic [3:0] EXT_MULTI = 4'h1;
    // ----------------------------------------
    // Fetch unit enable bits
    // ----------------------------------------
    localparam int IC_ECCI = 0;
    localparam int IC_ECCM = 1;
    localparam int IC_IDP  = 2;
    localparam int IC_IMTP = 3;
    localparam int IC_ISTP = 4;
    localparam int IC_L1TP = 5;
    localparam int IC_L2TP = 6;
    localparam int IC_FETCH_RD = 9;
    localparam logic [63:0] IC_CTL_IMPL = 64'h0000_0000_0000_027f;
    // ----------------------------------------
    // Bus unit enable register
    // ----------------------------------------
    localparam int BU_W       = 20;
    localparam int BU_RDE_ALL = 2;
    localparam logic [63:0] RST_ZERO = 64'h0;
    localparam int ADDR_MSB = 47;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef enum logic [3:0] {
        IE_SYS_FILL, IE_L2_FILL, IE_DATA_LOAD, IE_STAG_SNOOP,
        IE_STAG_VICT, IE_TAG_LOAD, IE_TAG_VICT, IE_L1TLB,
        IE_L1TLB_MM, IE_L2TLB, IE_L2TLB_MM, IE_SYS_RDERR
    } icbu_ierr_e;
    typedef struct packed {
        logic                 valid;
        icbu_ierr_e           kind;
        logic                 multibit;
        logic                 page_2m;
        logic [15:0]          code;
        logic [ADDR_MSB:0]    addr;
    } icbu_ierr_s;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [63:0] wdata;
    } icbu_msr_s;
    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [63:0] rdata;
    } icbu_rsp_s;
endpackage
`default_nettype wire

// >>> hdl/icbu_gate.sv
// Purpose : Global and local enable gating for a group of error classes
// Assumes : Events are one-cycle pulses on the core clock
// Notes   : Purely combinational, registered by the caller
`timescale 1ns/1ps
`default_nettype none
module icbu_gate #(
    parameter int W = 20
) (
    input  wire logic [W-1:0] events,
    input  wire logic [W-1:0] local_en,
    input  wire logic         global_en,
    output logic      [W-1:0] log_vec,
    output logic              signal
);
    // ----------------------------------------
    // Gating
    // ----------------------------------------
    // global gates logging
    assign log_vec = events & {W{global_en}};
    assign signal = |(log_vec & local_en);
endmodule
`default_nettype wire

// >>> hdl/icbu_bank.sv
// Purpose : Fetch-unit and bus-unit error reporting bank
// Assumes : Global enables come from core logic on SYS_CLK
// Notes   : MSR answer comes one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module icbu_bank (
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    input  wire icbu_pkg::icbu_msr_s  MSR_IN,
    output icbu_pkg::icbu_rsp_s       MSR_OUT,
    input  wire logic                 IC_GLOBAL_EN,
    input  wire logic                 BU_GLOBAL_EN,
    input  wire icbu_pkg::icbu_ierr_s IC_ERR,
    input  wire logic [19:0]          BU_ERR,
    output logic                      IC_MCE,
    output logic [19:0]               BU_LOG,
    output logic                      BU_MCE
);
    import icbu_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [63:0]     ic_ctl;
        logic [63:0]     ic_mask;
        logic [63:0]     ic_stat;
        logic [63:0]     ic_addr;
        logic [BU_W-1:0] bu_ctl;
        icbu_rsp_s       rsp;
        logic            ic_mce;
        logic [BU_W-1:0] bu_log;
        logic            bu_mce;
    } icbu_state_s;

    icbu_state_s st_q;
    icbu_state_s st_d;

    logic [BU_W-1:0] bu_log_c;
    logic            bu_sig_c;
    logic [0:0]      ic_log_c;
    logic            ic_sig_c;
    logic [0:0]      ic_loc_c;
    logic [63:0]     ic_stat_c;
    logic [63:0]     ic_amask_c;
    logic            wr_c;
    logic            hw_log_c;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Local enable for a fetch-unit error
    function automatic logic ic_local(
        input icbu_ierr_e      k,
        input logic            mb,
        input logic [63:0]     ctl,
        input logic [BU_W-1:0] bu
    );
        logic r;
        r = 1'b0;
        case (k)
            IE_SYS_FILL, IE_L2_FILL: begin
                r = mb ? ctl[IC_ECCM] : ctl[IC_ECCI];
            end
            IE_DATA_LOAD: begin
                r = ctl[IC_IDP];
            end
            IE_STAG_SNOOP, IE_STAG_VICT: begin
                r = ctl[IC_ISTP];
            end
            IE_TAG_LOAD, IE_TAG_VICT: begin
                r = ctl[IC_IMTP];
            end
            IE_L1TLB, IE_L1TLB_MM: begin
                r = ctl[IC_L1TP];
            end
            IE_L2TLB, IE_L2TLB_MM: begin
                r = ctl[IC_L2TP];
            end
            IE_SYS_RDERR: begin
                r = ctl[IC_FETCH_RD] & bu[BU_RDE_ALL];
            end
            default: begin
                r = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Mask of address bits that carry content
    function automatic logic [63:0] bits_hi_lo(input int hi, input int lo);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            if (i <= hi && i >= lo) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [63:0] addr_mask(
        input icbu_ierr_e k,
        input logic       p2m
    );
        logic [63:0] m;
        m = '0;
        case (k)
            IE_STAG_SNOOP, IE_SYS_FILL, IE_L2_FILL: begin
                m = bits_hi_lo(39, 6);
            end
            IE_TAG_LOAD: begin
                m = bits_hi_lo(ADDR_MSB, 6);
            end
            IE_DATA_LOAD: begin
                m = bits_hi_lo(ADDR_MSB, 4);
            end
            IE_L1TLB, IE_L1TLB_MM: begin
                m = p2m ? bits_hi_lo(ADDR_MSB, 20) : bits_hi_lo(ADDR_MSB, 12);
            end
            IE_L2TLB, IE_L2TLB_MM: begin
                m = bits_hi_lo(ADDR_MSB, 12);
            end
            default: begin
                m = '0;
            end
        endcase
        return m;
    endfunction

    // Status word for a freshly logged error
    function automatic logic [63:0] ic_status(
        input icbu_ierr_e  k,
        input logic        mb,
        input logic        en,
        input logic [15:0] code
    );
        logic [63:0] s;
        logic        fill;
        s    = '0;
        fill = (k == IE_SYS_FILL) || (k == IE_L2_FILL);
        s[ST_VALID] = 1'b1;
        s[ST_EN]    = en;
        s[ST_UNCOR]     = (fill & mb) | (k == IE_STAG_SNOOP) | (k == IE_STAG_VICT);
        s[ST_CTX_BAD]   = s[ST_UNCOR];
        s[ST_CORR_ECC]  = fill & ~mb;
        s[ST_UNCOR_ECC] = fill & mb;
        s[ST_SCRUB]     = 1'b0;
        s[ST_ADDR_VALID] = (addr_mask(k, 1'b0) != '0);
        if (k == IE_SYS_RDERR) begin
            s[ST_UNCOR]      = 1'b1;
            s[ST_CTX_BAD]    = 1'b0;
            s[ST_ADDR_VALID] = 1'b0;
        end
        if (k == IE_L1TLB_MM || k == IE_L2TLB_MM) begin
            s[ST_EXT +: 4] = EXT_MULTI;
        end else begin
            s[ST_EXT +: 4] = EXT_PLAIN;
        end
        s[15:0] = code;
        return s;
    endfunction

    // ----------------------------------------
    // Enable gating
    // ----------------------------------------
    // bus unit error classes
    icbu_gate #(
        .W(BU_W)
    ) u_bu_gate (
        .events    (BU_ERR),
        .local_en  (st_q.bu_ctl),
        .global_en (BU_GLOBAL_EN),
        .log_vec   (bu_log_c),
        .signal    (bu_sig_c)
    );

    // The fetch unit reuses the same gate with one class
    assign ic_loc_c[0] = ic_local(IC_ERR.kind, IC_ERR.multibit,
                                  st_q.ic_ctl, st_q.bu_ctl);

    icbu_gate #(
        .W(1)
    ) u_ic_gate (
        .events    (IC_ERR.valid),
        .local_en  (ic_loc_c),
        .global_en (IC_GLOBAL_EN),
        .log_vec   (ic_log_c),
        .signal    (ic_sig_c)
    );

    // Candidate status and address mask for this cycle
    assign ic_stat_c  = ic_status(IC_ERR.kind, IC_ERR.multibit,
                                  ic_loc_c[0], IC_ERR.code);
    assign ic_amask_c = addr_mask(IC_ERR.kind, IC_ERR.page_2m);
    assign hw_log_c   = ic_log_c[0];
    assign wr_c       = MSR_IN.req & MSR_IN.we;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        // Software writes first, hardware logging overrides below
        if (wr_c) begin
            case (MSR_IN.addr)
                ADR_IC_CTL: begin
                    st_d.ic_ctl = ((MSR_IN.wdata & ~st_q.ic_mask)
                                  | (MSR_IN.wdata & st_q.ic_ctl & st_q.ic_mask))
                                  & IC_CTL_IMPL;
                end
                ADR_IC_MASK: begin
                    st_d.ic_mask = MSR_IN.wdata;
                end
                ADR_IC_STAT: begin
                    st_d.ic_stat = MSR_IN.wdata;
                end
                ADR_IC_ADDR: begin
                    st_d.ic_addr = MSR_IN.wdata;
                end
                ADR_BU_CTL: begin
                    st_d.bu_ctl = MSR_IN.wdata[BU_W-1:0];
                end
                default: begin
                    st_d.ic_mask = st_q.ic_mask;
                end
            endcase
        end
        // A logged error wins over a same-cycle software write to the status word
        if (hw_log_c) begin
            if (st_q.ic_stat[ST_VALID]) begin
                st_d.ic_stat           = st_q.ic_stat;
                st_d.ic_stat[ST_OVER]  = 1'b1;
            end else begin
                st_d.ic_stat = ic_stat_c;
                st_d.ic_addr = {16'h0, IC_ERR.addr} & ic_amask_c;
            end
        end
        // Exception requests and bus log pulses
        st_d.ic_mce = ic_sig_c;
        st_d.bu_log = bu_log_c;
        st_d.bu_mce = bu_sig_c;
        // Read answer, unmapped numbers answer zero with hit low
        st_d.rsp.ack   = MSR_IN.req;
        st_d.rsp.hit   = 1'b0;
        st_d.rsp.rdata = '0;
        if (MSR_IN.req) begin
            st_d.rsp.hit = 1'b1;
            case (MSR_IN.addr)
                ADR_IC_CTL: begin
                    st_d.rsp.rdata = st_q.ic_ctl;
                end
                ADR_IC_MASK: begin
                    st_d.rsp.rdata = st_q.ic_mask;
                end
                ADR_IC_STAT: begin
                    st_d.rsp.rdata = st_q.ic_stat;
                end
                ADR_IC_ADDR: begin
                    st_d.rsp.rdata = st_q.ic_addr;
                end
                ADR_BU_CTL: begin
                    st_d.rsp.rdata = {{(64-BU_W){1'b0}}, st_q.bu_ctl};
                end
                default: begin
                    st_d.rsp.hit = 1'b0;
                end
            endcase
            if (MSR_IN.we) begin
                st_d.rsp.rdata = '0;
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Every control bit resets to zero, so exception signalling starts off
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign MSR_OUT = st_q.rsp;
    assign IC_MCE  = st_q.ic_mce;
    assign BU_LOG  = st_q.bu_log;
    assign BU_MCE  = st_q.bu_mce;
endmodule
`default_nettype wire

// >>> tb/icbu_bank_properties.sv
// Purpose : Port-level checks for the fetch/bus-unit error bank
// Assumes : One clock, synchronous active-high reset
// Notes   : Bound onto icbu_bank; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module icbu_bank_properties (
    input wire logic                 SYS_CLK,
    input wire logic                 RST,
    input wire icbu_pkg::icbu_msr_s  MSR_IN,
    input wire icbu_pkg::icbu_rsp_s  MSR_OUT,
    input wire logic                 IC_GLOBAL_EN,
    input wire logic                 BU_GLOBAL_EN,
    input wire icbu_pkg::icbu_ierr_s IC_ERR,
    input wire logic [19:0]          BU_ERR,
    input wire logic                 IC_MCE,
    input wire logic [19:0]          BU_LOG,
    input wire logic                 BU_MCE
);
    import icbu_pkg::*;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Outputs lag their cause by one edge, so skip the edge after reset
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    bu_log_gate_a: assert property (
        !$past(RST) |-> BU_LOG == ($past(BU_ERR) & {20{$past(BU_GLOBAL_EN)}}))
        else $error("bus log differs from gated events");
    bu_mce_cause_a: assert property (
        BU_MCE |-> $past(BU_GLOBAL_EN) && ($past(BU_ERR) != 20'h0))
        else $error("bus exception without enabled event");
    bu_mce_logged_a: assert property (BU_MCE |-> BU_LOG != 20'h0)
        else $error("bus exception without a logged class");
    ic_mce_cause_a: assert property (
        IC_MCE |-> $past(IC_GLOBAL_EN) && $past(IC_ERR.valid))
        else $error("fetch exception without enabled event");
    ack_timing_a: assert property (!$past(RST) |-> MSR_OUT.ack == $past(MSR_IN.req))
        else $error("register answer not one cycle after request");
    bu_ctl_zero_a: assert property (
        MSR_IN.req && !MSR_IN.we && MSR_IN.addr == ADR_BU_CTL |=> MSR_OUT.rdata[63:20] == 44'h0)
        else $error("reserved bus enable bits read nonzero");
    addr_width_a: assert property (
        MSR_IN.req && !MSR_IN.we && MSR_IN.addr == ADR_IC_ADDR |=> MSR_OUT.rdata[63:48] == 16'h0)
        else $error("error address wider than 48 bits");
    over_valid_a: assert property (
        MSR_IN.req && !MSR_IN.we && MSR_IN.addr == ADR_IC_STAT
        |=> !MSR_OUT.rdata[ST_OVER] || MSR_OUT.rdata[ST_VALID])
        else $error("overflow set without valid");
    ext_code_a: assert property (
        MSR_IN.req && !MSR_IN.we && MSR_IN.addr == ADR_IC_STAT |=> MSR_OUT.rdata[19:17] == 3'h0)
        else $error("extended error code out of range");
endmodule
bind icbu_bank icbu_bank_properties i_icbu_bank_properties (
    .SYS_CLK(SYS_CLK), .RST(RST), .MSR_IN(MSR_IN), .MSR_OUT(MSR_OUT),
    .IC_GLOBAL_EN(IC_GLOBAL_EN), .BU_GLOBAL_EN(BU_GLOBAL_EN), .IC_ERR(IC_ERR),
    .BU_ERR(BU_ERR), .IC_MCE(IC_MCE), .BU_LOG(BU_LOG), .BU_MCE(BU_MCE));
`default_nettype wire

// >>> tb/test_icbu_bank.sv
// Purpose : Self-checking bench for the fetch/bus-unit error bank
// Assumes : Stimulus at falling edges, results sampled after rising edges
// Notes   : Drivers queue expected results; a monitor pops them as they appear
`timescale 1ns/1ps
`default_nettype none
module test_icbu_bank;
    import icbu_pkg::*;
    logic        sys_clk;
    logic        rst;
    icbu_msr_s   msr_in;
    icbu_rsp_s   msr_out;
    logic        ic_global_en;
    logic        bu_global_en;
    icbu_ierr_s  ic_err;
    logic [19:0] bu_err;
    logic        ic_mce;
    logic [19:0] bu_log;
    logic        bu_mce;
    int          num_errors;
    int          num_checks;
    int          seed;
    logic [64:0] rsp_q[$];
    logic [21:0] evt_q[$];
    logic [63:0] v;
    logic [47:0] a;
    logic [19:0] e;
    icbu_bank i_icbu_bank (
        .SYS_CLK(sys_clk), .RST(rst), .MSR_IN(msr_in), .MSR_OUT(msr_out),
        .IC_GLOBAL_EN(ic_global_en), .BU_GLOBAL_EN(bu_global_en), .IC_ERR(ic_err),
        .BU_ERR(bu_err), .IC_MCE(ic_mce), .BU_LOG(bu_log), .BU_MCE(bu_mce));
    // ----------------------------------------
    // Clock, helpers and compare tasks
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Expected fetch status; other fields stay clear for these types
    function automatic logic [63:0] stat(logic unc, logic en, logic adv, logic [3:0] ext,
                                         logic [15:0] code);
        stat = 64'h8000_0000_0000_0000 | (64'(unc) << ST_UNCOR) | (64'(en) << ST_EN)
             | (64'(adv) << ST_ADDR_VALID) | (64'(ext) << ST_EXT) | 64'(code);
    endfunction
    task automatic chk_rsp(logic [64:0] got, logic [64:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected answer at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_evt(logic [21:0] got, logic [21:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected event at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Request holds for exactly one rising edge, answer expected next edge
    task automatic msr(logic we, logic [31:0] ad, logic [63:0] wd, logic hit, logic [63:0] exp);
        @(negedge sys_clk);
        msr_in <= '{req: 1'b1, we: we, addr: ad, wdata: wd};
        rsp_q.push_back({hit, exp});
        @(negedge sys_clk);
        msr_in.req <= 1'b0;
    endtask
    task automatic wr(logic [31:0] ad, logic [63:0] wd);
        msr(1'b1, ad, wd, 1'b1, 64'h0);
    endtask
    task automatic rd(logic [31:0] ad, logic [63:0] exp);
        msr(1'b0, ad, 64'h0, 1'b1, exp);
    endtask
    // Only nonzero outcomes are queued; a silent design leaves nothing to pop
    task automatic fire(icbu_ierr_s ie, logic [19:0] be, logic [21:0] exp);
        @(negedge sys_clk);
        ic_err <= ie;
        bu_err <= be;
        if (exp !== 22'h0) evt_q.push_back(exp);
        @(negedge sys_clk);
        ic_err.valid <= 1'b0;
        bu_err <= 20'h0;
    endtask
    task automatic finish_test;
        if (rsp_q.size() != 0 || evt_q.size() != 0) num_errors++;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Monitor: an unexpected result pops an unknown and so mismatches
    always @(posedge sys_clk) begin
        #1;
        if (msr_out.ack !== 1'b0)
            chk_rsp({msr_out.hit, msr_out.rdata}, rsp_q.size() ? rsp_q.pop_front() : 'x);
        if ({ic_mce, bu_mce, bu_log} !== 22'h0)
            chk_evt({ic_mce, bu_mce, bu_log}, evt_q.size() ? evt_q.pop_front() : 22'bx);
    end
    initial begin
        #20000;
        num_errors++;
        finish_test;
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'h42a8;
        num_errors = 0;
        num_checks = 0;
        rst = 1'b1;
        msr_in = '0;
        ic_err = '0;
        bu_err = '0;
        ic_global_en = 1'b0;
        bu_global_en = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        rd(ADR_BU_CTL, 64'h0);
        msr(1'b0, 32'h0000_0407, 64'h0, 1'b0, 64'h0);
        wr(ADR_BU_CTL, '1);
        rd(ADR_BU_CTL, 64'h0000_0000_000f_ffff);
        // Masked bits may be cleared but not set
        wr(ADR_IC_CTL, '1);
        rd(ADR_IC_CTL, IC_CTL_IMPL);
        wr(ADR_IC_MASK, 64'h21);
        wr(ADR_IC_CTL, 64'h0);
        wr(ADR_IC_CTL, '1);
        rd(ADR_IC_CTL, IC_CTL_IMPL & ~64'h21);
        wr(ADR_IC_MASK, 64'h0);
        // Each class bit alone; a neighbour class logs without exception
        bu_global_en = 1'b1;
        for (int n = 0; n < 20; n++) begin
            e = 20'h1 << n;
            wr(ADR_BU_CTL, 64'(e));
            fire('0, e, {2'b01, e});
            fire('0, {e[18:0], e[19]}, {2'b00, e[18:0], e[19]});
        end
        // Random enables, events and global gate
        for (int k = 0; k < 16; k++) begin
            v = {$random(seed), $random(seed)};
            wr(ADR_BU_CTL, v);
            e = 20'($random(seed));
            bu_global_en = 1'($random(seed));
            fire('0, e, bu_global_en ? {1'b0, |(e & v[19:0]), e} : 22'h0);
        end
        // Fetch errors: address range by type, overflow, extended code
        ic_global_en = 1'b1;
        wr(ADR_IC_CTL, 64'h20);
        a = 48'({$random(seed), $random(seed)});
        fire('{1'b1, IE_L1TLB, 1'b0, 1'b0, 16'h0015, a}, 20'h0, 22'h20_0000);
        rd(ADR_IC_STAT, stat(1'b0, 1'b1, 1'b1, EXT_PLAIN, 16'h0015));
        rd(ADR_IC_ADDR, {16'h0, a[47:12], 12'h0});
        fire('{1'b1, IE_L1TLB_MM, 1'b0, 1'b1, 16'h0016, a}, 20'h0, 22'h20_0000);
        rd(ADR_IC_STAT, stat(1'b0, 1'b1, 1'b1, EXT_PLAIN, 16'h0015) | 64'h1 << ST_OVER);
        wr(ADR_IC_STAT, 64'h0);
        fire('{1'b1, IE_L1TLB_MM, 1'b0, 1'b1, 16'h0016, a}, 20'h0, 22'h20_0000);
        rd(ADR_IC_STAT, stat(1'b0, 1'b1, 1'b1, EXT_MULTI, 16'h0016));
        rd(ADR_IC_ADDR, {16'h0, a[47:20], 20'h0});
        // Read-data error needs the all-operations bus enable as well
        wr(ADR_IC_STAT, 64'h0);
        wr(ADR_IC_CTL, 64'h200);
        wr(ADR_BU_CTL, 64'h0);
        fire('{1'b1, IE_SYS_RDERR, 1'b0, 1'b0, 16'h0017, a}, 20'h0, 22'h0);
        rd(ADR_IC_STAT, stat(1'b1, 1'b0, 1'b0, EXT_PLAIN, 16'h0017));
        rd(ADR_IC_ADDR, 64'h0);
        wr(ADR_IC_STAT, 64'h0);
        wr(ADR_BU_CTL, 64'h4);
        fire('{1'b1, IE_SYS_RDERR, 1'b0, 1'b0, 16'h0017, a}, 20'h0, 22'h20_0000);
        // Global fetch enable off: nothing logged
        wr(ADR_IC_STAT, 64'h0);
        ic_global_en = 1'b0;
        fire('{1'b1, IE_L1TLB, 1'b0, 1'b0, 16'h0018, a}, 20'h0, 22'h0);
        rd(ADR_IC_STAT, 64'h0);
        // Mid-run reset: control registers written above must return to zero
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        rd(ADR_BU_CTL, 64'h0);
        rd(ADR_IC_CTL, 64'h0);
        repeat (3) @(negedge sys_clk);
        finish_test;
    end
endmodule
`default_nettype wire
